// File: hdl/pfm_defines.svh
// Offsets, field positions, reset values and codes of the data mapping block.
// Assumes APB byte addresses on an 8-bit paddr.
`ifndef PFM_DEFINES_SVH
`define PFM_DEFINES_SVH

// ====================================
// Register map
`define PFM_ADR_CTRL 8'h00
`define PFM_ADR_STATREG 8'h04
`define PFM_ADR_OUT0 8'h08
`define PFM_ADR_OUT1 8'h0c
`define PFM_ADR_IN0 8'h10
`define PFM_ADR_IN1 8'h14
`define PFM_ADR_LINK 8'h18
`define PFM_ADR_INT_STAT 8'h1c
`define PFM_ADR_INT_MASK 8'h20

// ====================================
// Fields and reset values
`define PFM_CTRL_CLEAR_BIT 0
`define PFM_IN0_RST 16'h0000
`define PFM_IN1_RST 16'h0002
`define PFM_OUT0_RST 16'h0064
`define PFM_OUT1_RST 16'h0066
`define PFM_STATREG_RST 16'h00c8
`define PFM_STAT_NONE 16'hffff
`define PFM_INT_UP 0
`define PFM_INT_LOST 1
`define PFM_INT_MISMATCH 2
`define PFM_INT_RX 3

// ====================================
// Status word codes and node range
`define PFM_CPU_RUN 8'h00
`define PFM_CPU_STOP 8'h80
`define PFM_OK 8'h00
`define PFM_FAULT_ADDR 8'hf0
`define PFM_FAULT_HW_MAX 3'h5
`define PFM_FAULT_LINK 8'hf6
`define PFM_NODE_MIN 7'h01
`define PFM_NODE_MAX 7'h7d

`endif

// File: hdl/pfm_pkg.sv
// Types shared by the data mapping block.
// Assumes nothing of its surroundings.
package pfm_pkg;
  typedef logic [15:0] pfm_word_t;
  typedef enum logic [2:0] {SEQ_IDLE, SEQ_OUT, SEQ_CLR, SEQ_STAT, SEQ_IN} pfm_seq_e;
endpackage : pfm_pkg

// File: hdl/pfm_rst_sync.sv
// Reset release synchroniser.
// Assumes an active-low asynchronous reset input.
`timescale 1ns/1ps
module pfm_rst_sync (
  input wire logic clk,
  input wire logic reset_n,
  output logic rst_n
);
  logic meta_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      meta_r <= 1'b1;
      rst_n <= meta_r;
    end
  end
endmodule : pfm_rst_sync

// File: hdl/pfm_data_map.sv
// Cyclic data exchange of a fieldbus slave: maps master words to CPU data registers.
// Assumes a decoded fieldbus engine, a CPU data register port with ack, and an APB master.
`timescale 1ns/1ps
`include "pfm_defines.svh"
module pfm_data_map import pfm_pkg::*; (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [6:0] node_switch,
  input wire logic cpu_run,
  input wire logic [2:0] hw_fault,
  input wire logic fb_link_up,
  input wire logic fb_addr_valid,
  input wire logic [6:0] fb_node_addr,
  input wire logic fb_out_valid,
  input wire logic [1:0] fb_out_idx,
  input wire logic [15:0] fb_out_data,
  input wire logic fb_in_req,
  input wire logic [1:0] fb_in_idx,
  output logic fb_in_valid,
  output logic [15:0] fb_in_data,
  output logic d_req,
  output logic d_we,
  output logic [15:0] d_addr,
  output logic [15:0] d_wdata,
  input wire logic d_ack,
  input wire logic [15:0] d_rdata,
  output logic network_link_indicator,
  output logic irq
);
  // ====================================
  // Functions
  // Word index: bit 1 picks the slot, bit 0 the word inside it.
  function automatic pfm_word_t reg_num(input pfm_word_t start, input logic [1:0] idx);
    reg_num = start + {15'h0000, idx[0]};
  endfunction : reg_num

  function automatic logic [1:0] first_set(input logic [3:0] v);
    first_set = v[0] ? 2'h0 : v[1] ? 2'h1 : v[2] ? 2'h2 : 2'h3;
  endfunction : first_set

  // ====================================
  // Reset and state
  logic rst_n;
  logic pready_r, pslverr_r, clear_on_loss_r, link_up_r, irq_r, net_r;
  logic fb_in_valid_r, d_req_r, d_we_r;
  logic [31:0] prdata_r;
  logic [15:0] fb_in_data_r, d_addr_r, d_wdata_r, stat_dreg_r, stat_last_r;
  logic [3:0] int_stat_r, int_mask_r, ev, w1c, out_pend_r, clr_pend_r;
  logic [1:0] cur_idx_r, in_ptr_r, out_sel, clr_sel;
  pfm_word_t out_start_r [2];
  pfm_word_t in_start_r [2];
  pfm_word_t out_word_r [4];
  pfm_word_t in_word_r [4];
  pfm_seq_e seq_r;
  logic setup, wr, addr_ok, match, link_up_ev, link_lost_ev, rx_ev;
  logic [7:0] fault;
  pfm_word_t stat_val;

  pfm_rst_sync u_rst (
    .clk(clk),
    .reset_n(reset_n),
    .rst_n(rst_n)
  );

  // ====================================
  // APB slave, no wait states
  assign setup = psel & ~penable;
  assign wr = psel & penable & pready_r & pwrite;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= setup;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      if (setup) begin
        if (paddr == `PFM_ADR_CTRL) begin
          prdata_r <= {31'h0, clear_on_loss_r};
        end else if (paddr == `PFM_ADR_STATREG) begin
          prdata_r <= {16'h0000, stat_dreg_r};
        end else if (paddr == `PFM_ADR_OUT0) begin
          prdata_r <= {16'h0000, out_start_r[0]};
        end else if (paddr == `PFM_ADR_OUT1) begin
          prdata_r <= {16'h0000, out_start_r[1]};
        end else if (paddr == `PFM_ADR_IN0) begin
          prdata_r <= {16'h0000, in_start_r[0]};
        end else if (paddr == `PFM_ADR_IN1) begin
          prdata_r <= {16'h0000, in_start_r[1]};
        end else if (paddr == `PFM_ADR_LINK) begin
          prdata_r <= {14'h0, net_r, link_up_r, stat_val};
        end else if (paddr == `PFM_ADR_INT_STAT) begin
          prdata_r <= {28'h0, int_stat_r};
        end else if (paddr == `PFM_ADR_INT_MASK) begin
          prdata_r <= {28'h0, int_mask_r};
        end else begin
          pslverr_r <= 1'b1;
        end
      end
    end
  end

  // Start numbers kept per slot and per direction
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clear_on_loss_r <= 1'b0;
      stat_dreg_r <= `PFM_STATREG_RST;
      in_start_r[0] <= `PFM_IN0_RST;
      in_start_r[1] <= `PFM_IN1_RST;
      out_start_r[0] <= `PFM_OUT0_RST;
      out_start_r[1] <= `PFM_OUT1_RST;
      int_mask_r <= 4'h0;
    end else if (wr) begin
      if (paddr == `PFM_ADR_CTRL) begin
        clear_on_loss_r <= pwdata[`PFM_CTRL_CLEAR_BIT];
      end else if (paddr == `PFM_ADR_STATREG) begin
        stat_dreg_r <= pwdata[15:0];
      end else if (paddr == `PFM_ADR_OUT0) begin
        out_start_r[0] <= pwdata[15:0];
      end else if (paddr == `PFM_ADR_OUT1) begin
        out_start_r[1] <= pwdata[15:0];
      end else if (paddr == `PFM_ADR_IN0) begin
        in_start_r[0] <= pwdata[15:0];
      end else if (paddr == `PFM_ADR_IN1) begin
        in_start_r[1] <= pwdata[15:0];
      end else if (paddr == `PFM_ADR_INT_MASK) begin
        int_mask_r <= pwdata[3:0];
      end
    end
  end

  // ====================================
  // Link supervision
  assign addr_ok = (node_switch >= `PFM_NODE_MIN) && (node_switch <= `PFM_NODE_MAX);
  assign match = fb_node_addr == node_switch;
  assign link_up_ev = ~link_up_r & fb_link_up & fb_addr_valid & match & addr_ok;
  assign link_lost_ev = link_up_r & ~fb_link_up;
  // Two output words per slot; index covers both slots
  assign rx_ev = fb_out_valid & link_up_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_up_r <= 1'b0;
      net_r <= 1'b0;
    end else begin
      if (!fb_link_up) begin
        link_up_r <= 1'b0;
      end else if (link_up_ev) begin
        link_up_r <= 1'b1;
      end
      net_r <= link_up_r & fb_link_up & addr_ok;
    end
  end

  // ====================================
  // Interrupts; a new event beats a same-cycle clear
  assign ev = {rx_ev, fb_addr_valid & ~match, link_lost_ev, link_up_ev};
  assign w1c = (wr && paddr == `PFM_ADR_INT_STAT) ? pwdata[3:0] : 4'h0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_stat_r <= 4'h0;
      irq_r <= 1'b0;
    end else begin
      int_stat_r <= (int_stat_r & ~w1c) | ev;
      irq_r <= |(int_stat_r & int_mask_r);
    end
  end

  // ====================================
  // Status word
  always_comb begin
    if (!addr_ok) begin
      fault = `PFM_FAULT_ADDR;
    end else if (hw_fault != 3'h0) begin
      fault = `PFM_FAULT_ADDR | {5'h00, (hw_fault > `PFM_FAULT_HW_MAX) ? 3'h1 : hw_fault};
    end else if (!link_up_r) begin
      fault = `PFM_FAULT_LINK;
    end else begin
      fault = `PFM_OK;
    end
    stat_val = {cpu_run ? `PFM_CPU_RUN : `PFM_CPU_STOP, fault};
  end

  // ====================================
  // Master output words
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        out_word_r[i] <= 16'h0000;
      end
    end else if (rx_ev) begin
      out_word_r[fb_out_idx] <= fb_out_data;
    end else if (link_lost_ev && clear_on_loss_r) begin
      for (int i = 0; i < 4; i++) begin
        out_word_r[i] <= 16'h0000;
      end
    end
  end

  // Served from the local copy so the answer never waits on the CPU port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fb_in_valid_r <= 1'b0;
      fb_in_data_r <= 16'h0000;
    end else begin
      fb_in_valid_r <= fb_in_req;
      if (fb_in_req) begin
        fb_in_data_r <= in_word_r[fb_in_idx];
      end
    end
  end

  // ====================================
  // CPU register port sequencer
  // Order: received words, clear writes, status, input refresh.
  // Start numbers are per slot: index bit 1 picks the slot
  assign out_sel = first_set(out_pend_r);
  assign clr_sel = first_set(clr_pend_r);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_r <= SEQ_IDLE;
      d_req_r <= 1'b0;
      d_we_r <= 1'b0;
      d_addr_r <= 16'h0000;
      d_wdata_r <= 16'h0000;
      cur_idx_r <= 2'h0;
      in_ptr_r <= 2'h0;
      out_pend_r <= 4'h0;
      clr_pend_r <= 4'h0;
      stat_last_r <= `PFM_STAT_NONE;
      for (int i = 0; i < 4; i++) begin
        in_word_r[i] <= 16'h0000;
      end
    end else begin
      case (seq_r)
        SEQ_IDLE: begin
          if (out_pend_r != 4'h0) begin
            cur_idx_r <= first_set(out_pend_r);
            d_addr_r <= reg_num(out_start_r[out_sel[1]], out_sel);
            d_wdata_r <= out_word_r[first_set(out_pend_r)];
            d_we_r <= 1'b1;
            d_req_r <= 1'b1;
            seq_r <= SEQ_OUT;
          end else if (clr_pend_r != 4'h0) begin
            cur_idx_r <= first_set(clr_pend_r);
            d_addr_r <= reg_num(out_start_r[clr_sel[1]], clr_sel);
            d_wdata_r <= 16'h0000;
            d_we_r <= 1'b1;
            d_req_r <= 1'b1;
            seq_r <= SEQ_CLR;
          end else if (stat_val != stat_last_r) begin
            d_addr_r <= stat_dreg_r;
            d_wdata_r <= stat_val;
            stat_last_r <= stat_val;
            d_we_r <= 1'b1;
            d_req_r <= 1'b1;
            seq_r <= SEQ_STAT;
          end else if (link_up_r) begin
            // Refresh stops while offline, so input words hold
            cur_idx_r <= in_ptr_r;
            d_addr_r <= reg_num(in_start_r[in_ptr_r[1]], in_ptr_r);
            d_we_r <= 1'b0;
            d_req_r <= 1'b1;
            seq_r <= SEQ_IN;
          end
        end
        default: begin
          if (d_ack) begin
            d_req_r <= 1'b0;
            d_we_r <= 1'b0;
            seq_r <= SEQ_IDLE;
            if (seq_r == SEQ_OUT) begin
              out_pend_r[cur_idx_r] <= 1'b0;
            end else if (seq_r == SEQ_CLR) begin
              clr_pend_r[cur_idx_r] <= 1'b0;
            end else if (seq_r == SEQ_IN) begin
              in_ptr_r <= in_ptr_r + 2'h1;
              if (link_up_r) begin
                in_word_r[cur_idx_r] <= d_rdata;
              end
            end
          end
        end
      endcase
      // Later updates override the ack clears above: a word received in the ack cycle stays pending
      if (link_lost_ev && clear_on_loss_r) begin
        clr_pend_r <= 4'hf;
        out_pend_r <= 4'h0;
      end
      if (rx_ev) begin
        out_pend_r[fb_out_idx] <= 1'b1;
        clr_pend_r[fb_out_idx] <= 1'b0;
      end
      if (wr && paddr == `PFM_ADR_STATREG) begin
        stat_last_r <= `PFM_STAT_NONE;
      end
    end
  end

  // ====================================
  // Outputs
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign fb_in_valid = fb_in_valid_r;
  assign fb_in_data = fb_in_data_r;
  assign d_req = d_req_r;
  assign d_we = d_we_r;
  assign d_addr = d_addr_r;
  assign d_wdata = d_wdata_r;
  assign network_link_indicator = net_r;
  assign irq = irq_r;

  // ====================================
  // Assertions
  property p_out_map;
    @(posedge clk) disable iff (!rst_n)
      (d_req_r && seq_r == SEQ_OUT) |->
        d_addr_r == out_start_r[cur_idx_r[1]] + {15'h0000, cur_idx_r[0]};
  endproperty
  a_out_map: assert property (p_out_map) else $error("output word mapped wrongly");

  property p_in_map;
    @(posedge clk) disable iff (!rst_n)
      (d_req_r && seq_r == SEQ_IN) |->
        !d_we_r && d_addr_r == in_start_r[cur_idx_r[1]] + {15'h0000, cur_idx_r[0]};
  endproperty
  a_in_map: assert property (p_in_map) else $error("input word mapped wrongly");

  property p_hold_in;
    @(posedge clk) disable iff (!rst_n)
      (!link_up_r && $past(!link_up_r)) |-> $stable(in_word_r[0]) && $stable(in_word_r[3]);
  endproperty
  a_hold_in: assert property (p_hold_in) else $error("input changed while offline");

  property p_clear_out;
    @(posedge clk) disable iff (!rst_n)
      (link_lost_ev && clear_on_loss_r) |=>
        out_word_r[0] == 16'h0000 && out_word_r[1] == 16'h0000 && clr_pend_r == 4'hf;
  endproperty
  a_clear_out: assert property (p_clear_out) else $error("outputs not cleared");

  property p_hold_out;
    @(posedge clk) disable iff (!rst_n)
      (link_lost_ev && !clear_on_loss_r) |=> $stable(out_word_r[2]) && clr_pend_r == 4'h0;
  endproperty
  a_hold_out: assert property (p_hold_out) else $error("outputs lost in hold mode");

  property p_net;
    @(posedge clk) disable iff (!rst_n)
      net_r |-> $past(link_up_r) && $past(fb_link_up) && $past(addr_ok);
  endproperty
  a_net: assert property (p_net) else $error("indicator green without link");

  property p_stat;
    @(posedge clk) disable iff (!rst_n)
      (d_req_r && seq_r == SEQ_STAT) |-> d_we_r && d_addr_r == stat_dreg_r
        && d_wdata_r[15:8] inside {`PFM_CPU_RUN, `PFM_CPU_STOP}
        && (d_wdata_r[7:0] == `PFM_OK || d_wdata_r[7:4] == 4'hf);
  endproperty
  a_stat: assert property (p_stat) else $error("bad status word");

  property p_stat_run;
    @(posedge clk) disable iff (!rst_n)
      (seq_r == SEQ_IDLE && out_pend_r == 4'h0 && clr_pend_r == 4'h0
        && stat_val != stat_last_r) |=> seq_r == SEQ_STAT && d_wdata_r == $past(stat_val);
  endproperty
  a_stat_run: assert property (p_stat_run) else $error("status not written");

  property p_rx;
    @(posedge clk) disable iff (!rst_n)
      rx_ev |=> out_pend_r[$past(fb_out_idx)] && out_word_r[$past(fb_out_idx)] == $past(fb_out_data);
  endproperty
  a_rx: assert property (p_rx) else $error("received word not queued");
endmodule : pfm_data_map

// File: dv/pfm_master_model.sv
// Fieldbus master model: link, node addressing and cyclic words toward the slave.
// Assumes the slave samples its fieldbus inputs on the rising edge of clk.
`timescale 1ns/1ps
module pfm_master_model (
  input wire logic clk,
  output logic fb_link_up,
  output logic fb_addr_valid,
  output logic [6:0] fb_node_addr,
  output logic fb_out_valid,
  output logic [1:0] fb_out_idx,
  output logic [15:0] fb_out_data,
  output logic fb_in_req,
  output logic [1:0] fb_in_idx,
  input wire logic fb_in_valid,
  input wire logic [15:0] fb_in_data
);
  initial begin
    fb_link_up = 1'b0;
    fb_addr_valid = 1'b0;
    fb_node_addr = 7'h00;
    fb_out_valid = 1'b0;
    fb_out_idx = 2'h0;
    fb_out_data = 16'h0000;
    fb_in_req = 1'b0;
    fb_in_idx = 2'h0;
  end

  // ====================================
  // Link control
  task automatic connect(input logic [6:0] node);
    @(posedge clk);
    fb_link_up <= 1'b1;
    fb_addr_valid <= 1'b1;
    fb_node_addr <= node;
    @(posedge clk);
    fb_addr_valid <= 1'b0;
    // Released lines must not keep showing the old value
    fb_node_addr <= ~node;
  endtask : connect

  task automatic drop();
    @(posedge clk);
    fb_link_up <= 1'b0;
  endtask : drop

  // ====================================
  // Cyclic words, two out and two in per slot
  task automatic put_word(input logic [1:0] idx, input logic [15:0] data);
    @(posedge clk);
    fb_out_valid <= 1'b1;
    fb_out_idx <= idx;
    fb_out_data <= data;
    @(posedge clk);
    fb_out_valid <= 1'b0;
    fb_out_data <= ~data;
  endtask : put_word

  task automatic get_word(input logic [1:0] idx, output logic [15:0] data,
      output logic ok);
    @(posedge clk);
    fb_in_req <= 1'b1;
    fb_in_idx <= idx;
    @(posedge clk);
    fb_in_req <= 1'b0;
    // Answer stands for one cycle; sample it mid-cycle where it is settled
    @(negedge clk);
    ok = fb_in_valid;
    data = fb_in_data;
  endtask : get_word
endmodule : pfm_master_model

// File: dv/tb_pfm_data_map.sv
// Bench for the data mapping block: APB master, CPU register memory, fieldbus master.
// Assumes zero-wait APB answers and CPU accesses closed by one d_ack pulse.
`timescale 1ns/1ps
`include "pfm_defines.svh"
module tb_pfm_data_map import pfm_pkg::*; ();
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, cpu_run;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [6:0] node_switch, fb_node_addr;
  logic [2:0] hw_fault;
  logic fb_link_up, fb_addr_valid, fb_out_valid, fb_in_req, fb_in_valid;
  logic [1:0] fb_out_idx, fb_in_idx, cnt, dly;
  logic [15:0] fb_out_data, fb_in_data, d_addr, d_wdata, d_rdata;
  logic d_req, d_we, d_ack, network_link_indicator, irq;
  pfm_word_t mem [0:511];
  pfm_word_t wv [4] = '{16'h03e8, 16'h07d0, 16'ha5a5, 16'h5a5a};
  int err_total, num_checks;

  pfm_data_map uut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .node_switch(node_switch), .cpu_run(cpu_run), .hw_fault(hw_fault),
    .fb_link_up(fb_link_up), .fb_addr_valid(fb_addr_valid), .fb_node_addr(fb_node_addr),
    .fb_out_valid(fb_out_valid), .fb_out_idx(fb_out_idx), .fb_out_data(fb_out_data),
    .fb_in_req(fb_in_req), .fb_in_idx(fb_in_idx), .fb_in_valid(fb_in_valid),
    .fb_in_data(fb_in_data), .d_req(d_req), .d_we(d_we), .d_addr(d_addr),
    .d_wdata(d_wdata), .d_ack(d_ack), .d_rdata(d_rdata),
    .network_link_indicator(network_link_indicator), .irq(irq));

  pfm_master_model m (.clk(clk), .fb_link_up(fb_link_up), .fb_addr_valid(fb_addr_valid),
    .fb_node_addr(fb_node_addr), .fb_out_valid(fb_out_valid), .fb_out_idx(fb_out_idx),
    .fb_out_data(fb_out_data), .fb_in_req(fb_in_req), .fb_in_idx(fb_in_idx),
    .fb_in_valid(fb_in_valid), .fb_in_data(fb_in_data));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ====================================
  // CPU data registers; ack delay cycles through 0..3 for prompt and slow answers
  always @(posedge clk) begin
    if (d_ack) begin
      d_ack <= 1'b0;
      d_rdata <= ~d_rdata;
    end else if (d_req && cnt == dly) begin
      d_ack <= 1'b1;
      cnt <= 2'h0;
      dly <= dly + 2'h1;
      if (d_we) mem[d_addr[8:0]] <= d_wdata;
      else d_rdata <= mem[d_addr[8:0]];
    end else if (d_req) begin
      cnt <= cnt + 2'h1;
    end
  end

  // ====================================
  // Checks and report
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report

  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t: word %h expected %h", $time, got, exp);
    end
  endtask : chk_w

  task automatic chk_b(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t: bit %b expected %b", $time, got, exp);
    end
  endtask : chk_b

  // ====================================
  // APB master
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
    int n;
    logic got;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    got = 1'b0;
    rd = 32'h0000_0000;
    err = 1'b0;
    // Answer is taken mid-cycle, the request is held through the edge that samples it
    for (n = 0; n < 20 && !got; n++) begin
      @(negedge clk);
      got = (pready === 1'b1);
      if (got) begin
        rd = prdata;
        err = pslverr;
      end
      @(posedge clk);
    end
    if (!got) begin
      chk_b(1'b0, 1'b1);
      final_report();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk_w({r[31:1], e}, {exp[31:1], 1'b0} | {31'h0, 1'b0});
    chk_w(r, exp);
  endtask : rd_chk

  task automatic wait_mem(input logic [15:0] a, input pfm_word_t exp);
    for (int n = 0; n < 200 && mem[a[8:0]] !== exp; n++) @(posedge clk);
    chk_w({16'h0, mem[a[8:0]]}, {16'h0, exp});
  endtask : wait_mem

  task automatic wait_in(input logic [1:0] idx, input pfm_word_t exp);
    logic [15:0] d;
    logic ok;
    for (int n = 0; n < 40; n++) begin
      m.get_word(idx, d, ok);
      if (ok === 1'b1 && d === exp) break;
    end
    chk_w({15'h0, ok, d}, {15'h0, 1'b1, exp});
  endtask : wait_in

  // ====================================
  // Main sequence
  initial begin
    logic [31:0] r;
    logic e;
    logic [15:0] d;
    for (int i = 0; i < 512; i++) mem[i] = 16'h0000;
    {reset_n, psel, penable, pwrite, d_ack, cnt, dly} = '0;
    {paddr, pwdata, d_rdata, hw_fault} = '0;
    node_switch = 7'h01;
    cpu_run = 1'b1;
    err_total = 0;
    num_checks = 0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(`PFM_ADR_CTRL, 32'h0);
    rd_chk(`PFM_ADR_IN0, {16'h0, `PFM_IN0_RST});
    rd_chk(`PFM_ADR_IN1, {16'h0, `PFM_IN1_RST});
    rd_chk(`PFM_ADR_OUT0, {16'h0, `PFM_OUT0_RST});
    rd_chk(`PFM_ADR_OUT1, {16'h0, `PFM_OUT1_RST});
    rd_chk(`PFM_ADR_STATREG, {16'h0, `PFM_STATREG_RST});
    rd_chk(`PFM_ADR_INT_MASK, 32'h0);
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk_b(e, 1'b1);
    wait_mem(`PFM_STATREG_RST, {`PFM_CPU_RUN, `PFM_FAULT_LINK});
    $display("test reset done");
    for (int i = 0; i < 4; i++) mem[i] = 16'h1111 * 16'(i + 1);
    wr(`PFM_ADR_INT_MASK, 32'h1);
    m.connect(7'h01);
    repeat (3) @(posedge clk);
    chk_b(network_link_indicator, 1'b1);
    chk_b(irq, 1'b1);
    wr(`PFM_ADR_INT_STAT, 32'h1);
    repeat (3) @(posedge clk);
    chk_b(irq, 1'b0);
    rd_chk(`PFM_ADR_LINK, 32'h0003_0000);
    wait_mem(`PFM_STATREG_RST, 16'h0000);
    $display("test link up done");
    for (int i = 0; i < 4; i++) begin
      m.put_word(2'(i), wv[i]);
      wait_mem(16'(100 + i), wv[i]);
    end
    for (int i = 0; i < 4; i++) wait_in(2'(i), 16'h1111 * 16'(i + 1));
    $display("test exchange done");
    wr(`PFM_ADR_OUT0, 32'h12c);
    wr(`PFM_ADR_IN1, 32'h14);
    mem[250] = 16'hffff;
    wr(`PFM_ADR_STATREG, 32'hfa);
    mem[20] = 16'h7777;
    mem[21] = 16'h8888;
    m.put_word(2'h0, 16'hbeef);
    wait_mem(16'h012c, 16'hbeef);
    wait_in(2'h2, 16'h7777);
    wait_in(2'h3, 16'h8888);
    wait_mem(16'h00fa, 16'h0000);
    $display("test remap done");
    m.drop();
    repeat (3) @(posedge clk);
    chk_b(network_link_indicator, 1'b0);
    wait_mem(16'h00fa, {`PFM_CPU_RUN, `PFM_FAULT_LINK});
    mem[0] = 16'h9999;
    repeat (30) @(posedge clk);
    chk_w({16'h0, mem[300]}, 32'h0000_beef);
    m.get_word(2'h0, d, e);
    chk_w({15'h0, e, d}, 32'h0001_1111);
    $display("test hold done");
    wr(`PFM_ADR_CTRL, 32'h1);
    m.connect(7'h01);
    wait_in(2'h0, 16'h9999);
    m.put_word(2'h3, 16'h1234);
    wait_mem(16'd103, 16'h1234);
    m.drop();
    wait_mem(16'd300, 16'h0000);
    mem[0] = 16'h4444;
    wait_mem(16'd301, 16'h0000);
    wait_mem(16'd102, 16'h0000);
    wait_mem(16'd103, 16'h0000);
    m.get_word(2'h0, d, e);
    chk_w({15'h0, e, d}, 32'h0001_9999);
    $display("test clear done");
    wr(`PFM_ADR_CTRL, 32'h0);
    wr(`PFM_ADR_INT_STAT, 32'hf);
    m.connect(7'h02);
    repeat (3) @(posedge clk);
    chk_b(network_link_indicator, 1'b0);
    chk_b(irq, 1'b0);
    apb(1'b0, `PFM_ADR_INT_STAT, 32'h0, r, e);
    chk_b(r[`PFM_INT_MISMATCH], 1'b1);
    cpu_run <= 1'b0;
    wait_mem(16'h00fa, {`PFM_CPU_STOP, `PFM_FAULT_LINK});
    @(posedge clk);
    hw_fault <= 3'h3;
    wait_mem(16'h00fa, 16'h80f3);
    @(posedge clk);
    hw_fault <= 3'h0;
    node_switch <= 7'h00;
    wait_mem(16'h00fa, {`PFM_CPU_STOP, `PFM_FAULT_ADDR});
    $display("test status done");
    final_report();
  end
endmodule : tb_pfm_data_map
